// *** rtl/mar_limit_check.sv ***
`timescale 1ns/1ns
// compares a 3-bit reading against upper and lower limits, registered
module mar_limit_check (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic active, // comparison allowed
  input wire logic sample, // new reading valid
  input wire logic [2:0] reading, // measured level
  input wire logic [2:0] upper, // upper limit
  input wire logic [2:0] lower, // lower limit
  output logic over, // pulse: reading above upper
  output logic under // pulse: reading below lower
);
  typedef struct packed {
    logic over;
    logic under;
  } mar_chk_s;
  mar_chk_s st;
  mar_chk_s next_st;

  // strict compares: a reading equal to a limit raises nothing
  always_comb begin
    next_st.over = active && sample && (reading > upper);
    next_st.under = active && sample && (reading < lower);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign over = st.over;
  assign under = st.under;
endmodule

// *** rtl/mar_map.svh ***
`ifndef MAR_MAP_SVH
`define MAR_MAP_SVH
// register indices; byte address is index times four
`define MAR_IDX_VOLT1_LIMITS 8'h1A
`define MAR_IDX_TEMP_LIMITS 8'h1B
`define MAR_IDX_CAM_RX_ALARM_EN 8'h1C
`define MAR_IDX_SENSOR_ALARM_EN 8'h1D
`define MAR_IDX_BC_ALARM_EN 8'h1E
`define MAR_IDX_LANE_POL_SEL 8'h20
`define MAR_IDX_LP_LANE_POL 8'h21
`define MAR_IDX_HSRX_DEBUG_EN 8'h22
// registers without a printed offset
`define MAR_IDX_SENSOR_CTRL 8'h40
`define MAR_IDX_VOLT1_PEAK 8'h41
`define MAR_IDX_VOLT1_TROUGH 8'h42
`define MAR_IDX_IRQ_STATUS 8'h43
`define MAR_IDX_IRQ_ENABLE 8'h44
`define MAR_IDX_IRQ_CLEAR 8'h45
`define MAR_IDX_READINGS 8'h46
// reset values
`define MAR_RST_VOLT1_LIMITS 8'h62
`define MAR_RST_TEMP_LIMITS 8'h62
`define MAR_RST_CAM_RX_ALARM_EN 8'h3F
`define MAR_RST_SENSOR_ALARM_EN 8'h00
`define MAR_RST_BC_ALARM_EN 8'h00
`define MAR_RST_LANE_POL_SEL 8'h00
`define MAR_RST_LP_LANE_POL 8'h00
`define MAR_RST_HSRX_DEBUG_EN 8'h00
`define MAR_RST_SENSOR_CTRL 8'h0C
// writable-bit masks for registers with read-only bits
`define MAR_MASK_LANE_POL_SEL 8'h1F
`define MAR_MASK_HSRX_DEBUG_EN 8'h7F
// field positions
`define MAR_UPPER_LSB 4
`define MAR_LOWER_LSB 0
`define MAR_SENSE_ENABLE_LSB 2
`define MAR_SENSE_PIN_LSB 0
// sensor status bits
`define MAR_ST_TEMP_HIGH 3
`define MAR_ST_TEMP_LOW 2
`define MAR_ST_VOLT1_HIGH 1
`define MAR_ST_VOLT1_LOW 0
`define MAR_SENSE_ON 2'h3
`endif

// *** rtl/mar_pkg.sv ***
package mar_pkg;
  typedef logic [7:0] mar_byte_t;
  typedef logic [2:0] mar_level_t;
  typedef enum logic [1:0] {
    MAR_BUS_IDLE = 2'b00,
    MAR_BUS_DONE = 2'b01
  } mar_bus_e;
endpackage

// *** rtl/mar_regs.sv ***
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ns
`include "mar_map.svh"
// Notes on behaviour
// (RQ1) volt1_upper_limit sits in bits 6:4 (reset 6) and a sensing pin-1 reading above it alarms.
// (RQ2) volt1_lower_limit sits in bits 2:0 (reset 2) and a sensing pin-1 reading below it alarms.
// (RQ3) the highest and lowest voltage-1 readings are kept and readable.
// (RQ4) temp_upper_limit sits in bits 6:4 (reset 6) and a higher enabled reading alarms.
// (RQ5) temp_lower_limit sits in bits 2:0 (reset 2) and a lower enabled reading alarms.
// (RQ6) missing frame, lane sync and lane control alarm enables are bits 5:3, set at reset.
// (RQ7) header ECC, payload checksum and length alarm enables are bits 2:0, set at reset.
// (RQ8) six sensor alarm enables in bits 5:0 are clear at reset.
// (RQ9) seven back-channel alarm enables in bits 6:0 are clear at reset.
// (RQ10) lane swap bits 3:0 exchange P/N of data lanes, bit 4 of the clock lane.
// (RQ11) low-power polarity inverts the clock lane by bit 4 and data lanes by bits 3:0.
// (RQ12) software keeps the debug high-speed receive enable at zero in normal use.
// (RQ13) the sense pin field picks none, pin 0, pin 1 or both; volt1 limits need pin 1.
// (RQ14) the sensor enable field must read 11 for any limit comparison.
// (RQ15) a disabled alarm is kept off the combined alarm while detection continues.
// (RQ16) read-only reserved bits read 0; read/write reserved bits just store.
module mar_regs
  import mar_pkg::*;
(
  input wire logic clk, // 20 MHz system clock
  input wire logic reset_n, // async reset, active low
  input wire logic [9:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  output logic [1:0] avs_response, // 00 okay, 10 slave error
  input wire logic sample_valid, // new sensor readings, system clock
  input wire logic [2:0] volt1_reading, // voltage sensor 1 level
  input wire logic [2:0] temp_reading, // temperature level
  input wire logic [5:0] camera_rx_events, // receive error pulses
  input wire logic [6:0] back_channel_events, // back channel pulses
  input wire logic [1:0] volt0_events, // voltage 0 over/under pulses
  output logic [4:0] hs_lane_swap, // clock lane 4, data lanes 3:0
  output logic [4:0] lp_lane_invert, // clock lane 4, data lanes 3:0
  output logic [6:0] hsrx_debug, // debug receive enables
  output logic [3:0] sensor_status, // sticky temp/volt1 hi/lo
  output logic alarm, // combined enabled alarm
  output logic irq // level interrupt
);
  import mar_pkg::*;

  localparam int NEV = 19; // 6 rx, 6 sensor, 7 back channel

  typedef struct packed {
    mar_bus_e bus;
    mar_byte_t v1_lim;
    mar_byte_t t_lim;
    mar_byte_t rx_en;
    mar_byte_t sn_en;
    mar_byte_t bc_en;
    mar_byte_t pol;
    mar_byte_t lp_pol;
    mar_byte_t hsrx;
    mar_byte_t ctrl;
    mar_level_t peak;
    mar_level_t trough;
    logic seen;
    logic [3:0] sstat;
    logic [NEV-1:0] istat;
    logic [NEV-1:0] ien;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic alarm;
    logic irq;
    logic stall;
  } mar_regs_s;

  mar_regs_s st;
  mar_regs_s next_st;

  logic sensing;
  logic v1_active;
  logic volt1_over_alarm_en;
  logic volt1_under_alarm_en;
  logic t_over;
  logic t_under;

  // comparisons only run with both sensors enabled
  assign sensing = (st.ctrl[`MAR_SENSE_ENABLE_LSB +: 2] == `MAR_SENSE_ON); // RQ14
  // pin 1 selected in the pin field (10 or 11)
  assign v1_active = sensing && st.ctrl[`MAR_SENSE_PIN_LSB + 1]; // RQ13

  // same checker serves both sensors
  mar_limit_check u_volt1 (
    .clk(clk),
    .reset_n(reset_n),
    .active(v1_active),
    .sample(sample_valid),
    .reading(volt1_reading),
    .upper(st.v1_lim[`MAR_UPPER_LSB +: 3]),
    .lower(st.v1_lim[`MAR_LOWER_LSB +: 3]),
    .over(volt1_over_alarm_en),
    .under(volt1_under_alarm_en)
  );

  mar_limit_check u_temp (
    .clk(clk),
    .reset_n(reset_n),
    .active(sensing),
    .sample(sample_valid),
    .reading(temp_reading),
    .upper(st.t_lim[`MAR_UPPER_LSB +: 3]),
    .lower(st.t_lim[`MAR_LOWER_LSB +: 3]),
    .over(t_over),
    .under(t_under)
  );

  // event vector: [18:12] back channel, [11:6] sensor, [5:0] receive
  logic [NEV-1:0] events;
  logic [NEV-1:0] gates;
  assign events = {back_channel_events, t_over, t_under, volt1_over_alarm_en, volt1_under_alarm_en,
                   volt0_events, camera_rx_events};
  assign gates = {st.bc_en[6:0], st.sn_en[5:0], st.rx_en[5:0]};

  // one cycle of waitrequest, answer registered on the second cycle
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input logic lane, input logic [7:0] keep);
    merge = lane ? (wd & keep) : old;
  endfunction

  always_comb begin
    logic [7:0] idx;
    logic wr;
    logic rd;
    logic hit;
    logic [31:0] rv;
    logic [NEV-1:0] clr;
    idx = avs_address[9:2];
    wr = 1'b0;
    rd = 1'b0;
    hit = 1'b1;
    rv = 32'h0000_0000;
    clr = '0;
    next_st = st;
    next_st.resp = 2'b00;
    case (st.bus)
      MAR_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_st.bus = MAR_BUS_DONE;
          wr = avs_write;
          rd = avs_read;
        end
      end
      MAR_BUS_DONE: begin
        next_st.bus = MAR_BUS_IDLE;
      end
      default: begin
        next_st.bus = MAR_BUS_IDLE;
      end
    endcase
    // waitrequest kept in its own flop so the pin carries no decode glitch
    next_st.stall = (next_st.bus == MAR_BUS_IDLE);
    // read mux; reserved read-only bits come back zero
    case (idx)
      `MAR_IDX_VOLT1_LIMITS: rv[7:0] = st.v1_lim; // RQ1 RQ2
      `MAR_IDX_TEMP_LIMITS: rv[7:0] = st.t_lim; // RQ4 RQ5
      `MAR_IDX_CAM_RX_ALARM_EN: rv[7:0] = st.rx_en;
      `MAR_IDX_SENSOR_ALARM_EN: rv[7:0] = st.sn_en;
      `MAR_IDX_BC_ALARM_EN: rv[7:0] = st.bc_en;
      `MAR_IDX_LANE_POL_SEL: rv[7:0] = st.pol; // RQ16
      `MAR_IDX_LP_LANE_POL: rv[7:0] = st.lp_pol;
      `MAR_IDX_HSRX_DEBUG_EN: rv[7:0] = st.hsrx; // RQ12
      `MAR_IDX_SENSOR_CTRL: rv[7:0] = st.ctrl;
      `MAR_IDX_VOLT1_PEAK: rv[2:0] = st.peak; // RQ3
      `MAR_IDX_VOLT1_TROUGH: rv[2:0] = st.trough; // RQ3
      `MAR_IDX_IRQ_STATUS: rv[NEV-1:0] = st.istat;
      `MAR_IDX_IRQ_ENABLE: rv[NEV-1:0] = st.ien;
      `MAR_IDX_IRQ_CLEAR: rv = 32'h0000_0000;
      `MAR_IDX_READINGS: rv[7:0] = {1'b0, temp_reading, 1'b0, volt1_reading};
      default: hit = 1'b0;
    endcase
    if (rd) begin
      next_st.rdata = rv;
      next_st.resp = hit ? 2'b00 : 2'b10;
    end
    if (wr) begin
      next_st.resp = hit ? 2'b00 : 2'b10;
      case (idx)
        `MAR_IDX_VOLT1_LIMITS: next_st.v1_lim = merge(st.v1_lim, avs_writedata[7:0],
                                                      avs_byteenable[0], 8'hFF); // RQ1 RQ2
        `MAR_IDX_TEMP_LIMITS: next_st.t_lim = merge(st.t_lim, avs_writedata[7:0],
                                                    avs_byteenable[0], 8'hFF); // RQ4 RQ5
        `MAR_IDX_CAM_RX_ALARM_EN: next_st.rx_en = merge(st.rx_en, avs_writedata[7:0],
                                                        avs_byteenable[0], 8'hFF); // RQ6 RQ7
        `MAR_IDX_SENSOR_ALARM_EN: next_st.sn_en = merge(st.sn_en, avs_writedata[7:0],
                                                        avs_byteenable[0], 8'hFF); // RQ8
        `MAR_IDX_BC_ALARM_EN: next_st.bc_en = merge(st.bc_en, avs_writedata[7:0],
                                                    avs_byteenable[0], 8'hFF); // RQ9
        `MAR_IDX_LANE_POL_SEL: next_st.pol = merge(st.pol, avs_writedata[7:0],
                                                   avs_byteenable[0],
                                                   `MAR_MASK_LANE_POL_SEL); // RQ16
        `MAR_IDX_LP_LANE_POL: next_st.lp_pol = merge(st.lp_pol, avs_writedata[7:0],
                                                     avs_byteenable[0], 8'hFF); // RQ16
        `MAR_IDX_HSRX_DEBUG_EN: next_st.hsrx = merge(st.hsrx, avs_writedata[7:0],
                                                     avs_byteenable[0],
                                                     `MAR_MASK_HSRX_DEBUG_EN); // RQ16
        `MAR_IDX_SENSOR_CTRL: next_st.ctrl = merge(st.ctrl, avs_writedata[7:0],
                                                   avs_byteenable[0], 8'hFF);
        `MAR_IDX_IRQ_ENABLE: begin
          if (avs_byteenable[0]) next_st.ien[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) next_st.ien[15:8] = avs_writedata[15:8];
          if (avs_byteenable[2]) next_st.ien[NEV-1:16] = avs_writedata[NEV-1:16];
        end
        `MAR_IDX_IRQ_CLEAR: begin
          clr = avs_writedata[NEV-1:0] & {{(NEV-16){avs_byteenable[2]}},
                {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        end
        default: begin
        end
      endcase
    end
    // running extremes of voltage 1 while pin 1 is sensed; first sample seeds both
    if (v1_active && sample_valid) begin // RQ3
      next_st.seen = 1'b1;
      if (!st.seen || volt1_reading > st.peak) next_st.peak = volt1_reading;
      if (!st.seen || volt1_reading < st.trough) next_st.trough = volt1_reading;
    end
    // sensor status is sticky and cleared with the interrupt clear bits
    next_st.sstat[`MAR_ST_TEMP_HIGH] = t_over | (st.sstat[`MAR_ST_TEMP_HIGH] & ~clr[11]); // RQ4
    next_st.sstat[`MAR_ST_TEMP_LOW] = t_under | (st.sstat[`MAR_ST_TEMP_LOW] & ~clr[10]); // RQ5
    next_st.sstat[`MAR_ST_VOLT1_HIGH] = volt1_over_alarm_en | (st.sstat[`MAR_ST_VOLT1_HIGH] & ~clr[9]); // RQ1
    next_st.sstat[`MAR_ST_VOLT1_LOW] = volt1_under_alarm_en | (st.sstat[`MAR_ST_VOLT1_LOW] & ~clr[8]); // RQ2
    // detection always latches; set wins over a clear in the same cycle
    next_st.istat = events | (st.istat & ~clr); // RQ15
    // combined alarm only carries enabled conditions
    next_st.alarm = |(next_st.istat & gates); // RQ6 RQ7 RQ8 RQ9 RQ15
    next_st.irq = |(next_st.istat & next_st.ien);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.bus <= MAR_BUS_IDLE;
      st.stall <= 1'b1;
      st.v1_lim <= `MAR_RST_VOLT1_LIMITS; // RQ1 RQ2
      st.t_lim <= `MAR_RST_TEMP_LIMITS; // RQ4 RQ5
      st.rx_en <= `MAR_RST_CAM_RX_ALARM_EN; // RQ6 RQ7
      st.sn_en <= `MAR_RST_SENSOR_ALARM_EN; // RQ8
      st.bc_en <= `MAR_RST_BC_ALARM_EN; // RQ9
      st.pol <= `MAR_RST_LANE_POL_SEL;
      st.lp_pol <= `MAR_RST_LP_LANE_POL;
      st.hsrx <= `MAR_RST_HSRX_DEBUG_EN;
      st.ctrl <= `MAR_RST_SENSOR_CTRL;
    end else begin
      st <= next_st;
    end
  end

  // outputs come straight from registers
  assign avs_readdata = st.rdata;
  assign avs_response = st.resp;
  assign avs_waitrequest = st.stall;
  assign hs_lane_swap = st.pol[4:0]; // RQ10
  assign lp_lane_invert = st.lp_pol[4:0]; // RQ11
  assign hsrx_debug = st.hsrx[6:0];
  assign sensor_status = st.sstat;
  assign alarm = st.alarm;
  assign irq = st.irq;
endmodule

// *** sim/mar_regs_asserts.sv ***
`timescale 1ns/1ns
// pin-level checks on the register bank
module mar_regs_asserts (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic [9:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic [1:0] avs_response, // response code
  input wire logic sample_valid, // new readings
  input wire logic [4:0] hs_lane_swap, // lane swap
  input wire logic [4:0] lp_lane_invert, // low-power polarity
  input wire logic [6:0] hsrx_debug, // debug enables
  input wire logic [3:0] sensor_status // sticky status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] idx;
  logic mapped;
  // own decode of the map, so a design decode slip shows up
  assign idx = avs_address[9:2];
  assign mapped = (idx >= 8'h1A && idx <= 8'h1E) || (idx >= 8'h20 && idx <= 8'h22)
    || (idx >= 8'h40 && idx <= 8'h46);
  a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_answer_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  a_resp_code: assert property (!avs_waitrequest |-> avs_response == ($past(mapped) ? 2'b00 : 2'b10))
    else $error("wrong response code");
  a_resp_quiet: assert property (avs_waitrequest |-> avs_response == 2'b00)
    else $error("response outside answer cycle");
  a_unmapped_zero: assert property (!avs_waitrequest && $past(avs_read && !mapped) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_swap_cause: assert property ($changed(hs_lane_swap) |-> $past(avs_write && idx == 8'h20))
    else $error("lane swap changed without write");
  a_lp_cause: assert property ($changed(lp_lane_invert) |-> $past(avs_write && idx == 8'h21))
    else $error("lp polarity changed without write");
  a_debug_cause: assert property ($changed(hsrx_debug) |-> $past(avs_write && idx == 8'h22))
    else $error("debug enable changed without write");
  a_status_rise: assert property (|(sensor_status & ~$past(sensor_status)) |-> $past(sample_valid, 2))
    else $error("status set without sample");
  a_status_hold: assert property (|($past(sensor_status) & ~sensor_status) |-> $past(avs_write && idx == 8'h45))
    else $error("status dropped without clear");
endmodule

// *** sim/mar_sensor_model.sv ***
`timescale 1ns/1ns
// sensor and link-event source facing the register bank
module mar_sensor_model (
  input wire logic clk, // system clock
  output logic sample_valid, // reading strobe
  output logic [2:0] volt1_reading, // voltage 1 level
  output logic [2:0] temp_reading, // temperature level
  output logic [5:0] camera_rx_events, // receive error pulses
  output logic [6:0] back_channel_events, // back channel pulses
  output logic [1:0] volt0_events // voltage 0 pulses
);
  // quiet at start
  initial begin
    sample_valid = 1'b0;
    volt1_reading = 3'h0;
    temp_reading = 3'h0;
    camera_rx_events = 6'h00;
    back_channel_events = 7'h00;
    volt0_events = 2'h0;
  end
  // one-cycle reading; levels flip afterwards so a late sample reads wrong
  task automatic sample(input logic [2:0] v, input logic [2:0] t);
    @(posedge clk);
    sample_valid <= 1'b1;
    volt1_reading <= v;
    temp_reading <= t;
    @(posedge clk);
    sample_valid <= 1'b0;
    volt1_reading <= ~v;
    temp_reading <= ~t;
  endtask
  // one-cycle event pulses
  task automatic pulse(input logic [5:0] rx, input logic [6:0] bc, input logic [1:0] v0);
    @(posedge clk);
    camera_rx_events <= rx;
    back_channel_events <= bc;
    volt0_events <= v0;
    @(posedge clk);
    camera_rx_events <= 6'h00;
    back_channel_events <= 7'h00;
    volt0_events <= 2'h0;
  endtask
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  import mar_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, sample_valid, alarm, irq;
  logic [1:0] avs_response, rsp, volt0_events;
  logic [2:0] volt1_reading, temp_reading;
  logic [5:0] camera_rx_events;
  logic [6:0] back_channel_events, hsrx_debug;
  logic [4:0] hs_lane_swap, lp_lane_invert;
  logic [3:0] sensor_status;
  int error_cnt = 0;
  int tests_run = 0;
  mar_byte_t idxs [9] = '{8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h20, 8'h21, 8'h22, 8'h40};
  mar_byte_t rstv [9] = '{8'h62, 8'h62, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0C};
  mar_byte_t mask [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'hFF, 8'h7F, 8'hFF};
  // 20 MHz
  always #25 clk = ~clk;
  mar_regs DUT (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .sample_valid(sample_valid), .volt1_reading(volt1_reading), .temp_reading(temp_reading),
    .camera_rx_events(camera_rx_events), .back_channel_events(back_channel_events),
    .volt0_events(volt0_events), .hs_lane_swap(hs_lane_swap), .lp_lane_invert(lp_lane_invert),
    .hsrx_debug(hsrx_debug), .sensor_status(sensor_status), .alarm(alarm), .irq(irq));
  mar_sensor_model u_src (.clk(clk), .sample_valid(sample_valid), .volt1_reading(volt1_reading),
    .temp_reading(temp_reading), .camera_rx_events(camera_rx_events),
    .back_channel_events(back_channel_events), .volt0_events(volt0_events));
  task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one access; request held until waitrequest is seen low, answer taken then
  task acc(input logic wr, input mar_byte_t i, input logic [31:0] d);
    @(posedge clk);
    avs_address <= {i, 2'b00};
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // waitrequest judged at the rising edge; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // lets a pulse reach status, alarm and irq
  task idle;
    repeat (3) @(negedge clk);
  endtask
  task t_regs;
    for (int i = 0; i < 9; i++) begin
      acc(1'b0, idxs[i], 32'h0);
      chk("reset value", rd, {24'h0, rstv[i]});
      acc(1'b1, idxs[i], 32'hFF);
      acc(1'b0, idxs[i], 32'h0);
      chk("read back", rd, {24'h0, mask[i]});
    end
    chk("lane swap", hs_lane_swap, 5'h1F);
    chk("lp invert", lp_lane_invert, 5'h1F);
    chk("debug enable", hsrx_debug, 7'h7F);
    // back to defaults; debug enable returns to zero for normal use
    for (int i = 0; i < 9; i++) acc(1'b1, idxs[i], {24'h0, rstv[i]});
    chk("lane swap off", hs_lane_swap, 5'h00);
    acc(1'b1, 8'h30, 32'hFF);
    chk("unmapped write", rsp, 2'b10);
    acc(1'b0, 8'h30, 32'h0);
    chk("unmapped read", {rsp, rd[29:0]}, 32'h80000000);
  endtask
  task t_sense;
    acc(1'b1, 8'h40, 32'h00);
    u_src.sample(3'h7, 3'h7);
    idle();
    chk("sensing off", sensor_status, 4'h0);
    acc(1'b1, 8'h40, 32'h0D);
    u_src.sample(3'h7, 3'h7);
    idle();
    chk("pin 0 only", sensor_status, 4'h8);
    acc(1'b1, 8'h45, 32'hF00);
    acc(1'b1, 8'h40, 32'h0E);
    u_src.sample(3'h6, 3'h6);
    u_src.sample(3'h2, 3'h2);
    idle();
    chk("at limits", sensor_status, 4'h0);
    u_src.sample(3'h7, 3'h7);
    idle();
    chk("over", sensor_status, 4'hA);
    u_src.sample(3'h1, 3'h1);
    idle();
    chk("under", sensor_status, 4'hF);
    acc(1'b0, 8'h41, 32'h0);
    chk("peak", rd, 32'h7);
    acc(1'b0, 8'h42, 32'h0);
    chk("trough", rd, 32'h1);
    // model leaves the inverse of the last sample standing between strobes
    acc(1'b0, 8'h46, 32'h0);
    chk("live readings", rd, 32'h66);
    acc(1'b1, 8'h45, 32'hF00);
    chk("cleared", sensor_status, 4'h0);
  endtask
  task t_alarm;
    u_src.pulse(6'h21, 7'h40, 2'h0);
    idle();
    chk("rx alarm", {irq, alarm}, 2'b01);
    acc(1'b0, 8'h43, 32'h0);
    chk("irq status", rd, 32'h40021);
    acc(1'b1, 8'h45, 32'h40021);
    acc(1'b1, 8'h1C, 32'h3E);
    u_src.pulse(6'h01, 7'h00, 2'h0);
    idle();
    chk("masked", {irq, alarm}, 2'b00);
    acc(1'b1, 8'h44, 32'h1);
    idle();
    chk("irq on", irq, 1'b1);
    acc(1'b1, 8'h1C, 32'h3F);
    idle();
    chk("resumed", alarm, 1'b1);
    acc(1'b1, 8'h45, 32'h1);
    idle();
    chk("all clear", {irq, alarm}, 2'b00);
    acc(1'b1, 8'h1E, 32'h40);
    acc(1'b1, 8'h1D, 32'h01);
    u_src.pulse(6'h00, 7'h40, 2'h1);
    idle();
    chk("bc v0 alarm", alarm, 1'b1);
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_sense();
    t_alarm();
    end_sim();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule
bind mar_regs mar_regs_asserts u_chk (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .sample_valid(sample_valid),
  .hs_lane_swap(hs_lane_swap), .lp_lane_invert(lp_lane_invert), .hsrx_debug(hsrx_debug),
  .sensor_status(sensor_status));
